// [design/dpr_regs.svh]
// Register offsets, field positions and reset values of the dual-port RAM.
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH

`define DPR_OFS_CFG_A 12'h000
`define DPR_OFS_CFG_B 12'h004
`define DPR_OFS_STATUS 12'h008
`define DPR_OFS_DOUT_A 12'h00c
`define DPR_OFS_DOUT_B 12'h010
`define DPR_OFS_CLASH 12'h014
`define DPR_OFS_OPCNT_A 12'h018
`define DPR_OFS_OPCNT_B 12'h01c

`define DPR_HIT_CFG_A 3'h0
`define DPR_HIT_CFG_B 3'h1
`define DPR_HIT_STATUS 3'h2
`define DPR_HIT_DOUT_A 3'h3
`define DPR_HIT_DOUT_B 3'h4
`define DPR_HIT_CLASH 3'h5
`define DPR_HIT_OPCNT 3'h6
`define DPR_HIT_NONE 3'h7

`define DPR_CFG_RST 12'h004
`define DPR_WCODE_MAX 3'h4
`define DPR_STS_WW 0
`define DPR_STS_WR 1

`endif

// [design/dpr_pkg.sv]
// Types shared by the dual-port RAM modules.
package dpr_pkg;

  parameter int DPR_ADDR_W = 12;
  parameter int DPR_DATA_W = 16;

  typedef enum logic [1:0] {
    DPR_MODE_RW = 2'b00,
    DPR_MODE_RO = 2'b01,
    DPR_MODE_WO = 2'b10,
    DPR_MODE_RSV = 2'b11
  } dpr_mode_e;

  typedef enum logic [1:0] {
    DPR_APB_IDLE = 2'b00,
    DPR_APB_RESP = 2'b01
  } dpr_apb_e;

  typedef struct packed {
    logic clr_inv;
    logic we_inv;
    logic en_inv;
    logic clk_inv;
    logic [1:0] rsv_hi;
    dpr_mode_e mode;
    logic rsv_lo;
    logic [2:0] wcode;
  } dpr_cfg_s;

  typedef struct packed {
    logic port_clk;
    logic enable;
    logic write_enable;
    logic output_clear;
    logic [DPR_ADDR_W-1:0] address;
    logic [DPR_DATA_W-1:0] write_data_in;
  } dpr_pin_s;

  typedef struct packed {
    logic valid;
    logic we;
    logic clr;
    logic [DPR_ADDR_W-1:0] addr;
    logic [DPR_DATA_W-1:0] din;
  } dpr_op_s;

endpackage

// [design/dpr_port_front.sv]
// Port front end: finds the active port clock edge and samples the pins.
`timescale 1ns/1ps

module dpr_port_front (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Port pins and configuration.
  input dpr_pkg::dpr_pin_s pins,
  input dpr_pkg::dpr_cfg_s cfg,
  // Sampled operation, valid for one cycle.
  output dpr_pkg::dpr_op_s op
);

  typedef struct packed {
    logic clk_q;
    dpr_pkg::dpr_op_s op;
  } dpr_front_s;

  dpr_front_s st;
  dpr_front_s next_st;
  logic edge_hit;

  // Both sides of the edge test use the current polarity, so flipping it
  // while the port clock idles fakes no edge and needs no port disable.
  always_comb begin
    next_st = st;
    edge_hit = (pins.port_clk ^ cfg.clk_inv) && !(st.clk_q ^ cfg.clk_inv);
    next_st.clk_q = pins.port_clk;
    next_st.op.valid = edge_hit && (pins.enable ^ cfg.en_inv);
    if (edge_hit) begin
      next_st.op.we = pins.write_enable ^ cfg.we_inv;
      next_st.op.clr = pins.output_clear ^ cfg.clr_inv;
      next_st.op.addr = pins.address;
      next_st.op.din = pins.write_data_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign op = st.op;

  a_edge_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !((pins.port_clk ^ cfg.clk_inv) && !(st.clk_q ^ cfg.clk_inv))
    |=> !st.op.valid
  ) else $error("Port operation raised without an active clock edge.");

  a_enable_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !(pins.enable ^ cfg.en_inv) |=> !st.op.valid
  ) else $error("Port operation raised while the port was disabled.");

endmodule

// [design/dpr_ram_top.sv]
// Dual-port bit-addressed RAM with APB configuration and status.
`timescale 1ns/1ps
`include "dpr_regs.svh"

// Contract
// - 4096 shared bit cells, both ports reach all.
// - Widths 1 to 16 set depth and address.
// - Per-port mode read-write, read-only or write-only.
// - Read captures address on edge, returns word.
// - Write stores word and mirrors it out.
// - Port inputs sampled only on port edge.
// - No combinational address to output path.
// - Ports independent, no arbitration between them.
// - Read or write completes on one edge.
// - Output holds until next port operation.
// - Enable gates read, write and clear.
// - Write enable stores input and shows it.
// - Write enable low performs a read.
// - Output clear zeroes output; a write in the same op still stores.
// - Address A at width W covers A*W upward.
// - Same-cell write clash gives invalid data.
// - Clock, enable, write, clear polarity selectable.
module dpr_ram_top #(
  parameter int MEM_BITS = 4096,
  parameter int CNT_W = 16
) (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // RAM ports, index 0 is port A and index 1 is port B.
  input dpr_pkg::dpr_pin_s [1:0] port_in,
  output logic [1:0][15:0] read_data_out
);

  localparam int DW = dpr_pkg::DPR_DATA_W;
  localparam int AW = dpr_pkg::DPR_ADDR_W;

  typedef struct packed {
    logic [MEM_BITS-1:0] mem;
    logic [1:0][DW-1:0] dout;
    dpr_pkg::dpr_cfg_s [1:0] cfg;
    logic [1:0] sts;
    logic [AW-1:0] clash_cell;
    logic [1:0][CNT_W-1:0] opcnt;
    dpr_pkg::dpr_apb_e apb;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dpr_state_s;

  dpr_state_s st;
  dpr_state_s next_st;
  dpr_pkg::dpr_op_s [1:0] op;
  logic [1:0][AW-1:0] base;
  logic [1:0][4:0] wid;
  logic [1:0][DW-1:0] din_m;
  logic [1:0][DW-1:0] rd_word;
  logic [1:0] do_wr;
  logic [1:0] do_rd;
  logic overlap;
  logic [1:0] sts_set;
  logic [1:0] sts_clr;
  logic [1:0] cnt_clr;
  logic [2:0] hit;
  logic [31:0] rd_reg;

  // Codes past the widest port clamp to 16 bits rather than alias.
  function automatic logic [2:0] dpr_wcode(input logic [2:0] code);
    if (code > `DPR_WCODE_MAX) begin
      return `DPR_WCODE_MAX;
    end
    return code;
  endfunction

  function automatic logic [4:0] dpr_width(input logic [2:0] code);
    return 5'(5'h01 << dpr_wcode(code));
  endfunction

  // Address bits above the port depth fall off the top of the shift.
  function automatic logic [AW-1:0] dpr_base(
    input logic [AW-1:0] addr,
    input logic [2:0] code
  );
    return AW'(addr << dpr_wcode(code));
  endfunction

  function automatic logic [DW-1:0] dpr_slice(
    input logic [MEM_BITS-1:0] mem,
    input logic [AW-1:0] b,
    input logic [4:0] w
  );
    logic [DW-1:0] word;
    word = '0;
    for (int i = 0; i < DW; i++) begin
      if (i < int'(w)) begin
        word[i] = mem[AW'(b + AW'(i))];
      end
    end
    return word;
  endfunction

  function automatic logic [2:0] dpr_decode(input logic [11:0] a);
    if (a == `DPR_OFS_CFG_A) begin
      return `DPR_HIT_CFG_A;
    end else if (a == `DPR_OFS_CFG_B) begin
      return `DPR_HIT_CFG_B;
    end else if (a == `DPR_OFS_STATUS) begin
      return `DPR_HIT_STATUS;
    end else if (a == `DPR_OFS_DOUT_A) begin
      return `DPR_HIT_DOUT_A;
    end else if (a == `DPR_OFS_DOUT_B) begin
      return `DPR_HIT_DOUT_B;
    end else if (a == `DPR_OFS_CLASH) begin
      return `DPR_HIT_CLASH;
    end else if (a == `DPR_OFS_OPCNT_A || a == `DPR_OFS_OPCNT_B) begin
      return `DPR_HIT_OPCNT;
    end
    return `DPR_HIT_NONE;
  endfunction

  // Each port has its own front end; nothing arbitrates between them.
  for (genvar p = 0; p < 2; p++) begin : g_port
    dpr_port_front u_front (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .pins(port_in[p]),
      .cfg(st.cfg[p]),
      .op(op[p])
    );
  end

  always_comb begin
    next_st = st;
    for (int p = 0; p < 2; p++) begin
      wid[p] = dpr_width(st.cfg[p].wcode);
      base[p] = dpr_base(op[p].addr, st.cfg[p].wcode);
      din_m[p] = op[p].din & DW'((17'h00001 << wid[p]) - 17'h00001);
      rd_word[p] = dpr_slice(st.mem, base[p], wid[p]);
      do_wr[p] = op[p].valid && op[p].we
        && st.cfg[p].mode != dpr_pkg::DPR_MODE_RO;
      do_rd[p] = op[p].valid && !do_wr[p]
        && st.cfg[p].mode != dpr_pkg::DPR_MODE_WO;
    end
    overlap = op[0].valid && op[1].valid
      && ({1'b0, base[0]} < {1'b0, base[1]} + {8'h00, wid[1]})
      && ({1'b0, base[1]} < {1'b0, base[0]} + {8'h00, wid[0]});
    sts_set[`DPR_STS_WW] = overlap && do_wr[0] && do_wr[1];
    sts_set[`DPR_STS_WR] = overlap && (do_wr[0] != do_wr[1])
      && (do_rd[0] || do_rd[1]);
    if (sts_set != 2'h0) begin
      next_st.clash_cell = (base[0] > base[1]) ? base[0] : base[1];
    end
    // Port B is applied last, so a same-cell write clash keeps B's bits;
    // the cell is to be treated as invalid either way.
    for (int p = 0; p < 2; p++) begin
      if (do_wr[p]) begin
        for (int i = 0; i < DW; i++) begin
          if (i < int'(wid[p])) begin
            next_st.mem[AW'(base[p] + AW'(i))] = op[p].din[i];
          end
        end
      end
      // A reading port in a clash sees the old cells, which is invalid.
      if (op[p].valid && op[p].clr) begin
        next_st.dout[p] = '0;
      end else if (do_wr[p]) begin
        next_st.dout[p] = din_m[p];
      end else if (do_rd[p]) begin
        next_st.dout[p] = rd_word[p];
      end
    end
    hit = dpr_decode(paddr);
    if (hit == `DPR_HIT_CFG_A || hit == `DPR_HIT_CFG_B) begin
      rd_reg = 32'(st.cfg[hit[0]]);
    end else if (hit == `DPR_HIT_STATUS) begin
      rd_reg = 32'(st.sts);
    end else if (hit == `DPR_HIT_DOUT_A) begin
      rd_reg = 32'(st.dout[0]);
    end else if (hit == `DPR_HIT_DOUT_B) begin
      rd_reg = 32'(st.dout[1]);
    end else if (hit == `DPR_HIT_CLASH) begin
      rd_reg = 32'(st.clash_cell);
    end else if (hit == `DPR_HIT_OPCNT) begin
      rd_reg = 32'(st.opcnt[paddr[2]]);
    end else begin
      rd_reg = 32'h00000000;
    end
    sts_clr = 2'h0;
    cnt_clr = 2'h0;
    next_st.pready = 1'b0;
    case (st.apb)
      dpr_pkg::DPR_APB_IDLE: begin
        if (psel && penable) begin
          next_st.apb = dpr_pkg::DPR_APB_RESP;
          next_st.pready = 1'b1;
          next_st.pslverr = (hit == `DPR_HIT_NONE);
          next_st.prdata = pwrite ? 32'h00000000 : rd_reg;
        end
      end
      dpr_pkg::DPR_APB_RESP: begin
        next_st.apb = dpr_pkg::DPR_APB_IDLE;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h00000000;
        if (psel && penable && pwrite) begin
          if (hit == `DPR_HIT_CFG_A || hit == `DPR_HIT_CFG_B) begin
            next_st.cfg[hit[0]] = dpr_pkg::dpr_cfg_s'(pwdata[11:0]);
            next_st.cfg[hit[0]].rsv_hi = 2'h0;
            next_st.cfg[hit[0]].rsv_lo = 1'b0;
          end else if (hit == `DPR_HIT_STATUS) begin
            sts_clr = pwdata[1:0];
          end else if (hit == `DPR_HIT_OPCNT) begin
            cnt_clr[paddr[2]] = 1'b1;
          end
        end
      end
      default: begin
        next_st.apb = dpr_pkg::DPR_APB_IDLE;
      end
    endcase
    // A clash in the very cycle of a clear still leaves its flag set.
    next_st.sts = (st.sts & ~sts_clr) | sts_set;
    for (int p = 0; p < 2; p++) begin
      if (op[p].valid) begin
        next_st.opcnt[p] = CNT_W'(st.opcnt[p] + CNT_W'(1));
      end else if (cnt_clr[p]) begin
        next_st.opcnt[p] = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.cfg <= {2{dpr_pkg::dpr_cfg_s'(`DPR_CFG_RST)}};
      st.apb <= dpr_pkg::DPR_APB_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign read_data_out = st.dout;

  default clocking dpr_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  for (genvar p = 0; p < 2; p++) begin : g_chk
    a_clear_zero: assert property (
      ce && op[p].valid && op[p].clr |=> read_data_out[p] == 16'h0000
    ) else $error("Output clear did not zero the port output.");

    a_write_mirror: assert property (
      ce && do_wr[p] && !op[p].clr
      |=> read_data_out[p] == $past(din_m[p])
    ) else $error("Written word was not mirrored on the output.");

    a_write_store: assert property (
      ce && do_wr[p] && !sts_set[`DPR_STS_WW]
      |=> dpr_slice(st.mem, $past(base[p]), $past(wid[p]))
        == $past(din_m[p])
    ) else $error("Written word was not stored in one edge.");

    a_read_word: assert property (
      ce && do_rd[p] && !op[p].clr && sts_set == 2'h0
      |=> read_data_out[p]
        == dpr_slice(st.mem, $past(base[p]), $past(wid[p]))
    ) else $error("Read did not return the addressed cells.");

    a_hold_idle: assert property (
      ce && !op[p].valid |=> $stable(read_data_out[p])
    ) else $error("Port output changed with no port operation.");

    a_no_comb: assert property (
      $changed(read_data_out[p]) |-> $past(ce && op[p].valid)
    ) else $error("Port output changed outside a clocked operation.");

    a_ro_read: assert property (
      ce && op[p].valid && op[p].we && !op[p].clr
        && st.cfg[p].mode == dpr_pkg::DPR_MODE_RO
      |=> read_data_out[p] == $past(rd_word[p])
    ) else $error("Read-only port did not read on a write request.");

    a_wo_hold: assert property (
      ce && op[p].valid && !op[p].we && !op[p].clr
        && st.cfg[p].mode == dpr_pkg::DPR_MODE_WO
      |=> $stable(read_data_out[p])
    ) else $error("Write-only port changed its output on a read.");

    a_clear_keeps: assert property (
      ce && op[p].valid && op[p].clr && do_wr == 2'b00
      |=> $stable(st.mem)
    ) else $error("Output clear disturbed the memory cells.");

    a_count_step: assert property (
      ce && op[p].valid
      |=> st.opcnt[p] == CNT_W'($past(st.opcnt[p]) + 1)
    ) else $error("Port operation was not counted.");
  end

  a_apb_answer: assert property (
    ce && psel && penable && !pready |=> pready ##1 !pready
  ) else $error("APB answer did not come one cycle after access.");

  a_clash_sticky: assert property (
    ce && sts_set[`DPR_STS_WW] |=> st.sts[`DPR_STS_WW]
  ) else $error("Write clash was not flagged in status.");

  a_rw_clash: assert property (
    ce && sts_set[`DPR_STS_WR] |=> st.sts[`DPR_STS_WR]
  ) else $error("Write-read clash was not flagged in status.");

  a_status_keep: assert property (
    ce && st.sts[`DPR_STS_WW] && !sts_clr[`DPR_STS_WW]
    |=> st.sts[`DPR_STS_WW]
  ) else $error("Write clash flag dropped without a clear.");

  a_error_pulse: assert property (
    pslverr |-> pready
  ) else $error("Slave error raised without an answer.");

  a_rdata_idle: assert property (
    !pready |-> prdata == 32'h00000000
  ) else $error("Read data showed outside an answer.");

  a_cfg_reserved: assert property (
    st.cfg[0].rsv_hi == 2'h0 && st.cfg[1].rsv_hi == 2'h0
      && st.cfg[0].rsv_lo == 1'b0 && st.cfg[1].rsv_lo == 1'b0
  ) else $error("Reserved configuration bits were kept set.");

endmodule

// [tb/dpr_user_port.sv]
// User logic model that drives one RAM port from the bench.
`timescale 1ns/1ps

module dpr_user_port (
  // Clock.
  input wire logic pclk,
  // Port pins.
  output dpr_pkg::dpr_pin_s pins
);
  initial pins = '0;

  // The port clock stays low between operations. Released buses show the
  // inverse of their last value so that a stale sample cannot look right.
  // Only the clash scenario aims both ports at one cell at once.
  task automatic op(input logic en, input logic we, input logic clr,
                    input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    pins <= {1'b0, en, we, clr, a, d};
    @(posedge pclk);
    pins.port_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    pins <= {1'b0, 1'b0, ~we, ~clr, ~a, ~d};
  endtask
endmodule

// [tb/test_dual_port_block_ram.sv]
// Self-checking bench for the dual-port RAM.
`timescale 1ns/1ps
`include "dpr_regs.svh"

module test_dual_port_block_ram;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic ce = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dpr_pkg::dpr_pin_s pin_a;
  dpr_pkg::dpr_pin_s pin_b;
  logic [1:0][15:0] dout;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int checks = 0;

  always #2.5 pclk = ~pclk;

  dpr_ram_top dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_in({pin_b, pin_a}), .read_data_out(dout)
  );
  dpr_user_port u_pa (.pclk(pclk), .pins(pin_a));
  dpr_user_port u_pb (.pclk(pclk), .pins(pin_b));

  task automatic wrap_up();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // The got value is taken at the call; the wait for the falling edge only delays the compare.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    @(negedge pclk);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic s_reset();
    chk("out_a", 32'h0, 32'(dout[0]));
    chk("out_b", 32'h0, 32'(dout[1]));
    apb(1'b0, `DPR_OFS_CFG_A, 32'h0);
    chk("cfg_a", 32'h4, rd);
    apb(1'b0, `DPR_OFS_CFG_B, 32'h0);
    chk("cfg_b", 32'h4, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", 32'h0, rd);
  endtask

  task automatic s_rw();
    u_pa.op(1'b1, 1'b1, 1'b0, 12'h005, 16'ha5c3);
    chk("out_a", 32'ha5c3, 32'(dout[0]));
    u_pb.op(1'b1, 1'b0, 1'b0, 12'h005, 16'h0);
    chk("out_b", 32'ha5c3, 32'(dout[1]));
    repeat (6) @(posedge pclk);
    chk("hold_b", 32'ha5c3, 32'(dout[1]));
    fork
      u_pa.op(1'b1, 1'b1, 1'b0, 12'h009, 16'h1234);
      u_pb.op(1'b1, 1'b0, 1'b0, 12'h005, 16'h0);
    join
    chk("out_a", 32'h1234, 32'(dout[0]));
    chk("out_b", 32'ha5c3, 32'(dout[1]));
  endtask

  task automatic s_enable_clear();
    u_pa.op(1'b0, 1'b1, 1'b0, 12'h005, 16'h1111);
    chk("out_a", 32'h1234, 32'(dout[0]));
    u_pb.op(1'b1, 1'b0, 1'b0, 12'h005, 16'h0);
    chk("out_b", 32'ha5c3, 32'(dout[1]));
    u_pa.op(1'b1, 1'b1, 1'b1, 12'h006, 16'h7e7e);
    chk("out_a", 32'h0, 32'(dout[0]));
    u_pb.op(1'b1, 1'b0, 1'b0, 12'h006, 16'h0);
    chk("out_b", 32'h7e7e, 32'(dout[1]));
    u_pb.op(1'b0, 1'b0, 1'b1, 12'h006, 16'h0);
    chk("out_b", 32'h7e7e, 32'(dout[1]));
  endtask

  // Cells 80..95 hold a5c3; each width reads its low slice of them.
  task automatic s_width();
    int w;
    for (int c = 0; c < 5; c++) begin
      w = 1 << c;
      apb(1'b1, `DPR_OFS_CFG_B, 32'(c));
      u_pb.op(1'b1, 1'b0, 1'b0, 12'(80 / w), 16'h0);
      chk("slice", 32'(16'ha5c3 & 16'((1 << w) - 1)), 32'(dout[1]));
    end
    apb(1'b1, `DPR_OFS_CFG_B, 32'h2);
    u_pb.op(1'b1, 1'b0, 1'b0, 12'd21, 16'h0);
    chk("nibble", 32'hc, 32'(dout[1]));
    u_pb.op(1'b1, 1'b1, 1'b0, 12'd22, 16'h9);
    u_pa.op(1'b1, 1'b0, 1'b0, 12'h005, 16'h0);
    chk("merged", 32'ha9c3, 32'(dout[0]));
  endtask

  task automatic s_mode();
    apb(1'b1, `DPR_OFS_CFG_B, 32'h14);
    u_pb.op(1'b1, 1'b1, 1'b0, 12'h005, 16'hdead);
    chk("ro_out", 32'ha9c3, 32'(dout[1]));
    apb(1'b1, `DPR_OFS_CFG_B, 32'h24);
    u_pb.op(1'b1, 1'b0, 1'b0, 12'h006, 16'h0);
    chk("wo_hold", 32'ha9c3, 32'(dout[1]));
    u_pb.op(1'b1, 1'b1, 1'b0, 12'h007, 16'h3c3c);
    u_pa.op(1'b1, 1'b0, 1'b0, 12'h007, 16'h0);
    chk("wo_store", 32'h3c3c, 32'(dout[0]));
  endtask

  // With the enable inverted, a low enable pin starts the operation.
  task automatic s_polarity();
    apb(1'b1, `DPR_OFS_CFG_A, 32'h204);
    u_pa.op(1'b0, 1'b1, 1'b0, 12'h008, 16'h4242);
    chk("inv_en", 32'h4242, 32'(dout[0]));
    u_pa.op(1'b1, 1'b1, 1'b0, 12'h008, 16'h0);
    chk("inv_hold", 32'h4242, 32'(dout[0]));
    apb(1'b1, `DPR_OFS_CFG_A, 32'h804);
    u_pa.op(1'b1, 1'b0, 1'b0, 12'h008, 16'h0);
    chk("inv_clr", 32'h0, 32'(dout[0]));
    apb(1'b1, `DPR_OFS_CFG_A, 32'h404);
    u_pa.op(1'b1, 1'b0, 1'b0, 12'h009, 16'h6161);
    chk("inv_we", 32'h6161, 32'(dout[0]));
    apb(1'b1, `DPR_OFS_CFG_A, 32'h4);
  endtask

  // A port operation while the clock enable is low must leave no trace.
  task automatic s_freeze();
    @(posedge pclk);
    ce <= 1'b0;
    u_pa.op(1'b1, 1'b1, 1'b0, 12'h00c, 16'hbeef);
    @(posedge pclk);
    ce <= 1'b1;
    chk("frozen_out", 32'h6161, 32'(dout[0]));
    u_pa.op(1'b1, 1'b0, 1'b0, 12'h00c, 16'h0);
    chk("frozen_mem", 32'h0, 32'(dout[0]));
  endtask

  // Both ports hit one cell on purpose; only flags and the writer are judged.
  task automatic s_clash();
    apb(1'b1, `DPR_OFS_CFG_B, 32'h4);
    fork
      u_pa.op(1'b1, 1'b1, 1'b0, 12'h00a, 16'h1111);
      u_pb.op(1'b1, 1'b1, 1'b0, 12'h00a, 16'h2222);
    join
    apb(1'b0, `DPR_OFS_STATUS, 32'h0);
    chk("sts_ww", 32'h1, rd);
    apb(1'b0, `DPR_OFS_CLASH, 32'h0);
    chk("clash_cell", 32'ha0, rd);
    apb(1'b1, `DPR_OFS_STATUS, 32'h3);
    apb(1'b1, `DPR_OFS_OPCNT_A, 32'h0);
    fork
      u_pa.op(1'b1, 1'b1, 1'b0, 12'h00b, 16'h5a5a);
      u_pb.op(1'b1, 1'b0, 1'b0, 12'h00b, 16'h0);
    join
    chk("wr_mirror", 32'h5a5a, 32'(dout[0]));
    apb(1'b0, `DPR_OFS_STATUS, 32'h0);
    chk("sts_wr", 32'h2, rd);
    u_pa.op(1'b1, 1'b0, 1'b0, 12'h00b, 16'h0);
    chk("wr_store", 32'h5a5a, 32'(dout[0]));
    apb(1'b0, `DPR_OFS_DOUT_A, 32'h0);
    chk("dout_reg", 32'h5a5a, rd);
    apb(1'b0, `DPR_OFS_OPCNT_A, 32'h0);
    chk("opcnt_a", 32'h2, rd);
  endtask

  // A second reset in mid-run clears outputs, flags and cells.
  task automatic s_rst_mid();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("rst_out_a", 32'h0, 32'(dout[0]));
    apb(1'b0, `DPR_OFS_STATUS, 32'h0);
    chk("rst_sts", 32'h0, rd);
    u_pb.op(1'b1, 1'b0, 1'b0, 12'h00b, 16'h0);
    chk("rst_mem", 32'h0, 32'(dout[1]));
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_rw();
    s_enable_clear();
    s_width();
    s_mode();
    s_polarity();
    s_freeze();
    s_clash();
    s_rst_mid();
    wrap_up();
  end
endmodule
